// ### bench/clock_source_startup_control_sva.sv
// Checker for clock enables, fuse decode and interrupt level of the start-up block.
`timescale 1ns/1ps
module clock_source_startup_control_sva (
  input wire i_clock,
  input wire i_sys_rst,
  input wire [3:0] i_clock_source_select,
  input wire i_oscillator_swing_option,
  input wire i_sleep_request,
  input wire [1:0] i_sleep_mode,
  input wire i_wake_request,
  input wire i_ext_irq_pin,
  input wire [2:0] o_source_kind,
  input wire [1:0] o_crystal_range,
  input wire o_full_swing,
  input wire o_core_clock_en,
  input wire o_peripheral_clock_en,
  input wire o_program_memory_clock_en,
  input wire o_execution_hold,
  input wire o_ext_irq_level
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  function automatic [2:0] kind_of(input [3:0] s);
    kind_of = (s >= 4'ha) ? 3'h0 : (s == 4'h9) ? 3'h1 : (s >= 4'h5) ? 3'h2 :
      (s >= 4'h1) ? 3'h3 : 3'h4;
  endfunction

  chk_run_decode: assert property (
    o_core_clock_en |-> o_source_kind == kind_of(i_clock_source_select))
    else $error("source kind does not match select");
  chk_crystal_range: assert property (
    o_core_clock_en && i_clock_source_select >= 4'ha
    |-> {1'b0, o_crystal_range} == i_clock_source_select[3:1] - 3'h4)
    else $error("crystal range wrong");
  chk_swing_fuse: assert property (
    o_core_clock_en |-> o_full_swing == !i_oscillator_swing_option)
    else $error("swing option inverted wrongly");
  chk_hold_core: assert property (o_execution_hold == !o_core_clock_en)
    else $error("hold not inverse of core enable");
  chk_flash_core: assert property (o_program_memory_clock_en == o_core_clock_en)
    else $error("program memory clock differs from core");
  chk_core_periph: assert property (o_core_clock_en |-> o_peripheral_clock_en)
    else $error("core runs without peripheral clock");
  chk_sleep_stop: assert property (o_core_clock_en && i_sleep_request |=> !o_core_clock_en)
    else $error("core clock not stopped by sleep");
  chk_idle_periph: assert property (
    o_core_clock_en && i_sleep_request && i_sleep_mode == 2'h0 |=> o_peripheral_clock_en)
    else $error("idle sleep stopped peripheral clock");
  chk_deep_periph: assert property (
    o_core_clock_en && i_sleep_request && i_sleep_mode == 2'h1 |=> !o_peripheral_clock_en)
    else $error("power-down left peripheral clock");
  chk_idle_wake: assert property (
    !o_core_clock_en && o_peripheral_clock_en && i_wake_request |=> o_core_clock_en)
    else $error("idle wake late");
  chk_irq_level: assert property (i_ext_irq_pin [*8] |-> o_ext_irq_level)
    else $error("interrupt level not seen");
endmodule // clock_source_startup_control_sva

// ### bench/clock_source_startup_control_tb_top.sv
// Self-checking bench for the clock source and start-up control block.
`timescale 1ns/1ps
module clock_source_startup_control_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] sel = 4'h0;
  reg [1:0] st_sel = 2'h0;
  reg swing = 1'b1;
  reg src = 1'b0;
  reg wd = 1'b0;
  reg slp = 1'b0;
  reg [1:0] mode = 2'h0;
  reg wake = 1'b0;
  reg irq = 1'b0;
  wire [2:0] kind;
  wire [1:0] rng;
  wire fs, core, per, pm, hold, irql;
  integer n_fail = 0;
  integer compares = 0;
  integer i;

  always #4 clk = ~clk;

  clock_source_startup_control #(.STARTUP_16K_CYCLES(17'd20), .STARTUP_32K_CYCLES(17'd24),
    .RESET_SHORT_CYCLES(17'd8), .RESET_LONG_CYCLES(17'd16)) clock_source_startup_control_i (
    .i_clock(clk), .i_sys_rst(rst), .i_clock_source_select(sel), .i_startup_time_select(st_sel),
    .i_oscillator_swing_option(swing), .i_source_clock(src), .i_watchdog_osc(wd),
    .i_sleep_request(slp), .i_sleep_mode(mode), .i_wake_request(wake), .i_ext_irq_pin(irq),
    .o_source_kind(kind), .o_crystal_range(rng), .o_full_swing(fs), .o_core_clock_en(core),
    .o_peripheral_clock_en(per), .o_program_memory_clock_en(pm), .o_execution_hold(hold),
    .o_ext_irq_level(irql));

  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask

  // Each edge stays high and low four clocks, above the synchroniser's minimum.
  task edges(input reg on_wd, input integer n);
    repeat (n) begin
      if (on_wd) wd = 1'b1; else src = 1'b1;
      tick(4);
      if (on_wd) wd = 1'b0; else src = 1'b0;
      tick(4);
    end
  endtask

  task boot(input [3:0] s, input [1:0] t, input reg w);
    begin
      rst = 1'b1;
      sel = s;
      st_sel = t;
      swing = w;
      tick(3);
      rst = 1'b0;
      tick(3);
    end
  endtask

  task t_decode;
    for (i = 0; i < 16; i = i + 1) begin
      boot(i[3:0], 2'h0, i[0]);
      check(kind, (i >= 10) ? 0 : (i == 9) ? 1 : (i >= 5) ? 2 : (i >= 1) ? 3 : 4);
      check(rng, (i >= 10) ? i[3:1] - 4 : 0);
      check(fs, !i[0]);
      check(hold, 1);
    end
    $display("test decode done");
  endtask

  task t_start(input [3:0] s, input [1:0] t, input integer ns, input integer nw);
    begin
      boot(s, t, 1'b1);
      edges(1'b0, ns - 1);
      tick(8);
      check(hold, 1);
      edges(1'b0, 1);
      if (nw > 0) begin
        tick(8);
        check(hold, 1);
        edges(1'b1, nw - 1);
        tick(8);
        check(hold, 1);
        edges(1'b1, 1);
      end
      tick(8);
      check(hold, 0);
      check(pm, 1);
      $display("test start-up done");
    end
  endtask

  task t_sleep;
    begin
      mode = 2'h0;
      slp = 1'b1;
      tick(1);
      slp = 1'b0;
      check(core, 0);
      check(per, 1);
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      check(core, 1);
      mode = 2'h1;
      slp = 1'b1;
      tick(1);
      slp = 1'b0;
      check(per, 0);
      irq = 1'b1;
      tick(8);
      check(irql, 1);
      irq = 1'b0;
      edges(1'b0, 19);
      check(hold, 1);
      edges(1'b0, 1);
      tick(8);
      check(core, 1);
      mode = 2'h3;
      slp = 1'b1;
      tick(1);
      slp = 1'b0;
      check(per, 0);
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      check(core, 1);
      mode = 2'h2;
      slp = 1'b1;
      tick(1);
      slp = 1'b0;
      check(core, 0);
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      edges(1'b0, 19);
      check(hold, 1);
      edges(1'b0, 1);
      tick(8);
      check(pm, 1);
      $display("test sleep done");
    end
  endtask

  task stop_test;
    begin
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #(60000 * 8);
    n_fail = n_fail + 1;
    stop_test;
  end

  initial begin
    tick(3);
    check(kind, 3);
    check(hold, 1);
    t_decode;
    t_start(4'hf, 2'h3, 20, 16);
    t_start(4'he, 2'h0, 258, 8);
    t_start(4'h9, 2'h2, 24, 16);
    t_start(4'h7, 2'h3, 6, 8);
    t_start(4'h3, 2'h1, 6, 8);
    t_start(4'h0, 2'h0, 6, 0);
    t_start(4'hf, 2'h1, 20, 0);
    t_sleep;
    stop_test;
  end
endmodule // clock_source_startup_control_tb_top

bind clock_source_startup_control clock_source_startup_control_sva chk_i (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clock_source_select(i_clock_source_select),
  .i_oscillator_swing_option(i_oscillator_swing_option), .i_sleep_request(i_sleep_request),
  .i_sleep_mode(i_sleep_mode), .i_wake_request(i_wake_request), .i_ext_irq_pin(i_ext_irq_pin),
  .o_source_kind(o_source_kind), .o_crystal_range(o_crystal_range),
  .o_full_swing(o_full_swing), .o_core_clock_en(o_core_clock_en),
  .o_peripheral_clock_en(o_peripheral_clock_en),
  .o_program_memory_clock_en(o_program_memory_clock_en),
  .o_execution_hold(o_execution_hold), .o_ext_irq_level(o_ext_irq_level));

// ### hdl/clock_source_startup_control.v
// Clock source decode, start-up and reset delay timing, and sleep clock enables.
`timescale 1ns/1ps
`include "clock_startup_defines.vh"

module clock_source_startup_control #(
  parameter [16:0] STARTUP_16K_CYCLES = `STARTUP_16K_CK,
  parameter [16:0] STARTUP_32K_CYCLES = `STARTUP_32K_CK,
  parameter [16:0] RESET_SHORT_CYCLES = `RESET_SHORT_CYCLES,
  parameter [16:0] RESET_LONG_CYCLES = `RESET_LONG_CYCLES
) (
  input wire i_clock,
  input wire i_sys_rst,
  input wire [3:0] i_clock_source_select,
  input wire [1:0] i_startup_time_select,
  input wire i_oscillator_swing_option,
  input wire i_source_clock,
  input wire i_watchdog_osc,
  input wire i_sleep_request,
  input wire [1:0] i_sleep_mode,
  input wire i_wake_request,
  input wire i_ext_irq_pin,
  output reg [2:0] o_source_kind,
  output reg [1:0] o_crystal_range,
  output reg o_full_swing,
  output wire o_core_clock_en,
  output wire o_peripheral_clock_en,
  output wire o_program_memory_clock_en,
  output wire o_execution_hold,
  output reg o_ext_irq_level
);

  localparam [2:0] ST_CAPTURE = 3'h0;
  localparam [2:0] ST_SOURCE_START = 3'h1;
  localparam [2:0] ST_RESET_DELAY = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_SLEEP = 3'h4;
  localparam [2:0] ST_WAKE_START = 3'h5;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Bit 0 source clock, bit 1 watchdog oscillator, bit 2 external interrupt.
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  reg [2:0] sync3_q;
  reg [2:0] level_q;
  reg [2:0] level_d;
  wire src_edge;
  wire wdt_edge;

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      level_q <= 3'h0;
    end else begin
      sync1_q <= {i_ext_irq_pin, i_watchdog_osc, i_source_clock};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_level
      always @* begin
        level_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : level_q[g];
      end
    end
  endgenerate

  assign src_edge = level_d[0] & ~level_q[0];
  assign wdt_edge = level_d[1] & ~level_q[1];

  // The interrupt path never depends on the peripheral clock enable.
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ext_irq_level <= 1'b0;
    end else begin
      o_ext_irq_level <= level_q[2];
    end
  end

  // ----------------------------------------------------------------
  // Fuse capture and decode
  // ----------------------------------------------------------------
  reg [3:0] source_sel_q;
  reg [1:0] startup_sel_q;
  reg swing_q;
  reg [2:0] kind;
  reg [1:0] range;
  reg [16:0] startup_count;
  reg [1:0] reset_delay;
  reg [2:0] state_q;
  reg [2:0] state_d;

  // Fuses are straps: taken by a clocked process at the first edge after reset.
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      source_sel_q <= `SHIPPED_SOURCE_SELECT;
      startup_sel_q <= `SHIPPED_STARTUP_SELECT;
      swing_q <= 1'b1;
    end else if (state_q == ST_CAPTURE) begin
      source_sel_q <= i_clock_source_select;
      startup_sel_q <= i_startup_time_select;
      swing_q <= i_oscillator_swing_option;
    end
  end

  always @* begin
    range = 2'h0;
    if (source_sel_q >= `SOURCE_CRYSTAL_MIN) begin
      kind = `KIND_CRYSTAL;
      case (source_sel_q[3:1])
        3'h5: range = `RANGE_LOW;
        3'h6: range = `RANGE_MID;
        default: range = `RANGE_HIGH;
      endcase
    end else if (source_sel_q == `SOURCE_LOW_FREQ) begin
      kind = `KIND_LOW_FREQ;
    end else if (source_sel_q >= `SOURCE_EXT_RC_MIN) begin
      kind = `KIND_EXT_RC;
    end else if (source_sel_q >= `SOURCE_INT_RC_MIN) begin
      kind = `KIND_INT_RC;
    end else begin
      kind = `KIND_EXT_CLOCK;
    end
  end

  always @* begin
    startup_count = `STARTUP_6_CK;
    reset_delay = `DELAY_NONE;
    case (kind)
      `KIND_CRYSTAL: begin
        // The index is the low select bit above the two start-up select bits.
        case ({source_sel_q[0], startup_sel_q})
          3'h0: begin
            startup_count = `STARTUP_258_CK;
            reset_delay = `DELAY_SHORT;
          end
          3'h1: begin
            startup_count = `STARTUP_258_CK;
            reset_delay = `DELAY_LONG;
          end
          3'h2: begin
            startup_count = `STARTUP_1K_CK;
            reset_delay = `DELAY_NONE;
          end
          3'h3: begin
            startup_count = `STARTUP_1K_CK;
            reset_delay = `DELAY_SHORT;
          end
          3'h4: begin
            startup_count = `STARTUP_1K_CK;
            reset_delay = `DELAY_LONG;
          end
          3'h5: begin
            startup_count = STARTUP_16K_CYCLES;
            reset_delay = `DELAY_NONE;
          end
          3'h6: begin
            startup_count = STARTUP_16K_CYCLES;
            reset_delay = `DELAY_SHORT;
          end
          default: begin
            startup_count = STARTUP_16K_CYCLES;
            reset_delay = `DELAY_LONG;
          end
        endcase
      end
      `KIND_LOW_FREQ: begin
        startup_count = startup_sel_q[1] ? STARTUP_32K_CYCLES : `STARTUP_1K_CK;
        reset_delay = (startup_sel_q == 2'h0) ? `DELAY_SHORT : `DELAY_LONG;
      end
      `KIND_EXT_RC: begin
        startup_count = (startup_sel_q == 2'h3) ? `STARTUP_6_CK : `STARTUP_18_CK;
        case (startup_sel_q)
          2'h0: reset_delay = `DELAY_NONE;
          2'h2: reset_delay = `DELAY_LONG;
          default: reset_delay = `DELAY_SHORT;
        endcase
      end
      default: begin
        startup_count = `STARTUP_6_CK;
        case (startup_sel_q)
          2'h0: reset_delay = `DELAY_NONE;
          2'h1: reset_delay = `DELAY_SHORT;
          default: reset_delay = `DELAY_LONG;
        endcase
      end
    endcase
  end

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_source_kind <= `KIND_INT_RC;
      o_crystal_range <= 2'h0;
      o_full_swing <= 1'b0;
    end else begin
      o_source_kind <= kind;
      o_crystal_range <= range;
      o_full_swing <= ~swing_q;
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  reg [16:0] count_q;
  reg [16:0] count_d;
  reg [16:0] reset_target;
  reg [1:0] sleep_mode_q;
  wire wake;
  wire src_done;
  wire wdt_done;

  assign wake = i_wake_request | level_q[2];

  always @* begin
    reset_target = (reset_delay == `DELAY_LONG) ? RESET_LONG_CYCLES : RESET_SHORT_CYCLES;
  end

  assign src_done = src_edge && (count_q == startup_count - 17'h00001);
  assign wdt_done = wdt_edge && (count_q == reset_target - 17'h00001);

  always @* begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      ST_CAPTURE: begin
        state_d = ST_SOURCE_START;
        count_d = 17'h0;
      end
      ST_SOURCE_START, ST_WAKE_START: begin
        if (src_done) begin
          count_d = 17'h0;
          if (state_q == ST_SOURCE_START && reset_delay != `DELAY_NONE) begin
            state_d = ST_RESET_DELAY;
          end else begin
            state_d = ST_RUN;
          end
        end else if (src_edge) begin
          count_d = count_q + 17'h00001;
        end
      end
      ST_RESET_DELAY: begin
        if (wdt_done) begin
          state_d = ST_RUN;
          count_d = 17'h0;
        end else if (wdt_edge) begin
          count_d = count_q + 17'h00001;
        end
      end
      ST_RUN: begin
        if (i_sleep_request) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          count_d = 17'h0;
          if (sleep_mode_q == `SLEEP_POWER_DOWN || sleep_mode_q == `SLEEP_POWER_SAVE) begin
            state_d = ST_WAKE_START;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      default: begin
        state_d = ST_CAPTURE;
        count_d = 17'h0;
      end
    endcase
  end

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_CAPTURE;
      count_q <= 17'h0;
      sleep_mode_q <= `SLEEP_IDLE;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      if (state_q == ST_RUN && i_sleep_request) begin
        sleep_mode_q <= i_sleep_mode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  assign o_core_clock_en = (state_q == ST_RUN);
  assign o_program_memory_clock_en = o_core_clock_en;
  assign o_peripheral_clock_en = o_core_clock_en ||
      (state_q == ST_SLEEP && sleep_mode_q == `SLEEP_IDLE);
  assign o_execution_hold = ~o_core_clock_en;

endmodule // clock_source_startup_control

// ### hdl/clock_startup_defines.vh
// Constants for the clock source selector and start-up timer.
`ifndef CLOCK_STARTUP_DEFINES_VH
`define CLOCK_STARTUP_DEFINES_VH

`define SHIPPED_SOURCE_SELECT 4'h1
`define SHIPPED_STARTUP_SELECT 2'h2

`define SOURCE_CRYSTAL_MIN 4'ha
`define SOURCE_LOW_FREQ 4'h9
`define SOURCE_EXT_RC_MIN 4'h5
`define SOURCE_INT_RC_MIN 4'h1

`define KIND_CRYSTAL 3'h0
`define KIND_LOW_FREQ 3'h1
`define KIND_EXT_RC 3'h2
`define KIND_INT_RC 3'h3
`define KIND_EXT_CLOCK 3'h4

`define RANGE_LOW 2'h1
`define RANGE_MID 2'h2
`define RANGE_HIGH 2'h3

`define DELAY_NONE 2'h0
`define DELAY_SHORT 2'h1
`define DELAY_LONG 2'h2

`define SLEEP_IDLE 2'h0
`define SLEEP_POWER_DOWN 2'h1
`define SLEEP_POWER_SAVE 2'h2
`define SLEEP_STANDBY 2'h3

`define COUNT_WIDTH 17
`define STARTUP_6_CK 17'h00006
`define STARTUP_18_CK 17'h00012
`define STARTUP_258_CK 17'h00102
`define STARTUP_1K_CK 17'h00400
`define STARTUP_16K_CK 17'h04000
`define STARTUP_32K_CK 17'h08000
`define RESET_SHORT_CYCLES 17'h01000
`define RESET_LONG_CYCLES 17'h10000

`endif
